// ===== core/tms_pkg.sv
// package for the timer mode and status block
// assumes one 100 MHz clock shared with the counter logic
package tms_pkg;
  // ==========================================
  // sizes and register map
  localparam int N_CH = 3;                 // channel count
  localparam logic [2:0] IDX_MODE = 3'h0;  // timer_mode_select
  localparam logic [2:0] IDX_STA  = 3'h1;  // match_a_status
  localparam logic [2:0] IDX_STB  = 3'h2;  // match_b_status
  localparam logic [2:0] IDX_WRP  = 3'h3;  // wrap_status
  // ==========================================
  // field positions
  localparam int QUAD_BIT = 6;   // quad_count_mode_bit
  localparam int WRAP_CONDITION_BIT_BIT = 5;   // wrap_condition_bit
  localparam int PWM_LSB  = 0;   // pulse-width bits 2..0
  localparam int EN_LSB   = 4;   // irq enables 6..4
  localparam int FLG_LSB  = 0;   // flags 2..0
  // ==========================================
  // reset values, reserved bits read as one
  localparam logic [7:0] MODE_RSVD = 8'h98;
  localparam logic [7:0] STAT_RSVD = 8'h88;
  // ==========================================
  // carriers
  typedef struct packed {
    logic [2:0] match_a;  // compare equal or capture into a
    logic [2:0] match_b;  // compare equal or capture into b
    logic [2:0] ovf;      // counter ffff to 0000
    logic       udf2;     // channel 2 counter 0000 to ffff
  } chan_evt_t;
  typedef struct packed {
    logic [2:0] o;   // pin level
    logic [2:0] oe;  // pin drive enable
  } io_t;
  typedef struct packed {
    logic [2:0] a;   // match a requests
    logic [2:0] b;   // match b requests
    logic [2:0] w;   // wrap requests
  } irq_t;
  typedef struct packed {
    logic quad;      // channel 2 in quadrature mode
    logic cnt_en;    // one-cycle count strobe
    logic cnt_down;  // direction of that strobe
  } ch2_ctl_t;
  typedef struct packed {
    logic [2:0] pwm;    // pulse-width mode per channel
    logic       quad;   // quadrature counting
    logic       wrap_condition_bit;   // wrap on overflow only
    logic [2:0] en_a;   // match a enables
    logic [2:0] en_b;   // match b enables
    logic [2:0] en_w;   // wrap enables
    logic [2:0] fl_a;   // match a flags
    logic [2:0] fl_b;   // match b flags
    logic [2:0] fl_w;   // wrap flags
    logic [2:0] arm_a;  // flags read as one
    logic [2:0] arm_b;
    logic [2:0] arm_w;
    logic       wreq;   // avalon waitrequest
    logic [7:0] rdata;  // read data byte
    logic [1:0] sy_a;   // phase a synchroniser
    logic [1:0] sy_b;   // phase b synchroniser
    logic       pa;     // previous phase a
    logic       pb;     // previous phase b
    logic [2:0] lvl;    // pwm levels
    ch2_ctl_t   ch2;
    io_t        pin;
    irq_t       irq;
  } state_t;
endpackage

// ===== core/timer_mode_status.sv
// mode select and interrupt status for a three channel 16-bit timer
// assumes counters, compares and prescaler sit next to it on clk_in
// and an avalon-mm master on the same clock
//
// Operation
// - quad bit makes ch2 updown from pins
// - one count per edge of either phase
// - quad mode ignores ch2 edge and source
// - clear, compare and flags stay active
// - wrap bit picks overflow only or both
// - reserved bits ignore writes, read one
// - pwm pin sets on a, clears on b
// - match a flag on compare or capture
// - a enables 6..4, flags 2..0, and-ed
// - dma start clears its match a flag
// - flags take only zero writes
// - match b flag on compare or capture
// - b enables 6..4, flags 2..0, and-ed
// - wrap enables 6..4 request with flag
// - status registers start at 88 hex
// - mode fields read zero after reset, reserved bits one
// - ch2 underflow flags only in quad mode
// - mode register starts at 98 hex
// - pwm mode ignores compare output select
//
// Chosen here: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/100ps
module timer_mode_status (
  input  wire logic                clk_in,
  input  wire logic                rst_in,
  input  wire logic                standby_in,
  input  wire logic [2:0]          av_address_in,
  input  wire logic                av_read_in,
  input  wire logic                av_write_in,
  input  wire logic [31:0]         av_writedata_in,
  input  wire logic [3:0]          av_byteenable_in,
  output logic [31:0]              av_readdata_out,
  output logic                     av_waitrequest_out,
  input  wire logic                ext_clk_a_pin_in,
  input  wire logic                ext_clk_b_pin_in,
  input  wire logic                ch2_norm_tick_in,
  input  wire tms_pkg::chan_evt_t  evt_in,
  input  wire logic [2:0]          dma_start_a_in,
  input  wire tms_pkg::io_t        cmp_io_in,
  output tms_pkg::io_t             chan_a_pin_out,
  output tms_pkg::irq_t            irq_out,
  output tms_pkg::ch2_ctl_t        ch2_out
);
  import tms_pkg::*;

  // ==========================================
  // elaboration check
  // the flag and field layout fits exactly three channels
  if (N_CH != 3) begin : g_bad_ch
    $error("timer status block serves exactly three channels");
  end

  // ==========================================
  // helpers
  // new flag value: armed zero writes clear, events set
  function automatic logic [2:0] flag_next(
    input logic [2:0] fl,
    input logic [2:0] set,
    input logic [2:0] arm,
    input logic       wr,
    input logic [2:0] wd
  );
    logic [2:0] clr;
    clr = wr ? (arm & ~wd) : 3'h0;
    // set wins over a clear in the same cycle
    return (fl & ~clr) | set;
  endfunction

  // status byte layout shared by the three status registers
  function automatic logic [7:0] stat_byte(
    input logic [2:0] en,
    input logic [2:0] fl
  );
    logic [7:0] v;
    v = STAT_RSVD;
    v[EN_LSB +: 3] = en;
    v[FLG_LSB +: 3] = fl;
    return v;
  endfunction

  // quadrature step, result is {up, down}
  function automatic logic [1:0] quad_step(
    input logic pa,
    input logic pb,
    input logic a,
    input logic b
  );
    logic ar, af, br, bf, up, dn;
    ar = a & ~pa;
    af = ~a & pa;
    br = b & ~pb;
    bf = ~b & pb;
    dn = (ar & ~b) | (br & a) | (af & b) | (bf & ~a);
    up = (ar & b) | (br & ~a) | (af & ~b) | (bf & a);
    // both phases moving at once gives no direction
    if (up & dn) begin
      return 2'h0;
    end
    return {up, dn};
  endfunction

  // ==========================================
  // state
  state_t s_q;   // all registered state
  state_t s_d;   // its next value

  logic       acc;    // bus request accepted this edge
  logic       wr_acc; // accepted write with low lane
  logic [7:0] wd;     // write data byte
  logic [2:0] w2set;  // wrap set terms
  logic [1:0] step;   // quadrature step

  // ==========================================
  // next state
  always_comb begin
    s_d = s_q;
    acc = (av_read_in | av_write_in) & ~s_q.wreq;
    wr_acc = acc & av_write_in & av_byteenable_in[0];
    wd = av_writedata_in[7:0];
    w2set = 3'h0;
    step = 2'h0;

    // phase pins: two flops, then edge history
    s_d.sy_a = {s_q.sy_a[0], ext_clk_a_pin_in};
    s_d.sy_b = {s_q.sy_b[0], ext_clk_b_pin_in};
    s_d.pa = s_q.sy_a[1];
    s_d.pb = s_q.sy_b[1];

    // bus handshake: one wait cycle, then the answer
    if (s_q.wreq) begin
      if (av_read_in | av_write_in) begin
        s_d.wreq = 1'b0;
      end
    end else begin
      s_d.wreq = 1'b1;       // transfer done at this edge
    end

    // read data is fetched while waitrequest is high
    if (s_q.wreq & av_read_in) begin
      unique case (av_address_in)
        IDX_MODE: begin
          s_d.rdata = MODE_RSVD;
          s_d.rdata[QUAD_BIT] = s_q.quad;
          s_d.rdata[WRAP_CONDITION_BIT_BIT] = s_q.wrap_condition_bit;
          s_d.rdata[PWM_LSB +: 3] = s_q.pwm;
        end
        IDX_STA: begin
          s_d.rdata = stat_byte(s_q.en_a, s_q.fl_a);
          s_d.arm_a = s_q.arm_a | s_q.fl_a;
        end
        IDX_STB: begin
          s_d.rdata = stat_byte(s_q.en_b, s_q.fl_b);
          s_d.arm_b = s_q.arm_b | s_q.fl_b;
        end
        IDX_WRP: begin
          s_d.rdata = stat_byte(s_q.en_w, s_q.fl_w);
          s_d.arm_w = s_q.arm_w | s_q.fl_w;
        end
        // unmapped words read as zero
        default: begin
          s_d.rdata = 8'h00;
        end
      endcase
    end

    // mode register write, reserved bits dropped
    if (wr_acc && av_address_in == IDX_MODE) begin
      s_d.quad = wd[QUAD_BIT];
      s_d.wrap_condition_bit = wd[WRAP_CONDITION_BIT_BIT];
      s_d.pwm = wd[PWM_LSB +: 3];
    end

    // enables are plain read/write bits
    if (wr_acc && av_address_in == IDX_STA) begin
      s_d.en_a = wd[EN_LSB +: 3];
    end
    if (wr_acc && av_address_in == IDX_STB) begin
      s_d.en_b = wd[EN_LSB +: 3];
    end
    if (wr_acc && av_address_in == IDX_WRP) begin
      s_d.en_w = wd[EN_LSB +: 3];
    end

    // wrap set terms, ch2 underflow only counts in quad mode
    w2set = evt_in.ovf;
    w2set[2] = evt_in.ovf[2] |
               (evt_in.udf2 & s_q.quad & ~s_q.wrap_condition_bit);

    // flags: a read arms, a zero write clears, events set
    s_d.fl_a = flag_next(s_q.fl_a & ~dma_start_a_in,
                         evt_in.match_a, s_q.arm_a,
                         wr_acc && av_address_in == IDX_STA, wd[2:0]);
    s_d.fl_b = flag_next(s_q.fl_b, evt_in.match_b,
                         s_q.arm_b,
                         wr_acc && av_address_in == IDX_STB, wd[2:0]);
    s_d.fl_w = flag_next(s_q.fl_w, w2set, s_q.arm_w,
                         wr_acc && av_address_in == IDX_WRP, wd[2:0]);

    // a write to a status register ends its read arming
    if (acc && av_write_in && av_address_in == IDX_STA) begin
      s_d.arm_a = 3'h0;
    end
    if (acc && av_write_in && av_address_in == IDX_STB) begin
      s_d.arm_b = 3'h0;
    end
    if (acc && av_write_in && av_address_in == IDX_WRP) begin
      s_d.arm_w = 3'h0;
    end

    // channel 2 count strobe
    // in quad mode the prescaler tick is not looked at
    step = quad_step(s_q.pa, s_q.pb, s_q.sy_a[1], s_q.sy_b[1]);
    s_d.ch2.quad = s_d.quad;
    if (s_q.quad) begin
      s_d.ch2.cnt_en = step[1] | step[0];
      s_d.ch2.cnt_down = step[0];
    end else begin
      s_d.ch2.cnt_en = ch2_norm_tick_in;
      s_d.ch2.cnt_down = 1'b0;
    end

    // pwm levels: b match clears last so it wins a tie
    for (int i = 0; i < N_CH; i++) begin
      if (evt_in.match_a[i]) begin
        s_d.lvl[i] = 1'b1;
      end
      if (evt_in.match_b[i]) begin
        s_d.lvl[i] = 1'b0;
      end
      // pwm pin drives always; else the compare output path
      if (s_d.pwm[i]) begin
        s_d.pin.o[i] = s_d.lvl[i];
        s_d.pin.oe[i] = 1'b1;
      end else begin
        s_d.pin.o[i] = cmp_io_in.o[i];
        s_d.pin.oe[i] = cmp_io_in.oe[i];
      end
    end

    // requests follow the next flags, no extra delay
    s_d.irq.a = s_d.fl_a & s_d.en_a;
    s_d.irq.b = s_d.fl_b & s_d.en_b;
    s_d.irq.w = s_d.fl_w & s_d.en_w;

    // reset and standby give the documented initial state
    if (rst_in | standby_in) begin
      s_d = '0;
      s_d.wreq = 1'b1;
      // keep sampling pins so no false edge after release
      s_d.sy_a = {s_q.sy_a[0], ext_clk_a_pin_in};
      s_d.sy_b = {s_q.sy_b[0], ext_clk_b_pin_in};
      s_d.pa = s_q.sy_a[1];
      s_d.pb = s_q.sy_b[1];
    end
  end

  // ==========================================
  // state register
  always_ff @(posedge clk_in) begin
    s_q <= s_d;
  end

  // ==========================================
  // outputs, all straight from flops
  assign av_readdata_out = {24'h000000, s_q.rdata};
  assign av_waitrequest_out = s_q.wreq;
  assign chan_a_pin_out = s_q.pin;
  assign irq_out = s_q.irq;
  assign ch2_out = s_q.ch2;

  // ==========================================
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in | standby_in);

  logic quiet;  // no bus answer or channel 0 dma start
  assign quiet = s_q.wreq & ~dma_start_a_in[0];

  sequence s_a_rise_b_low;
    s_q.quad && s_q.sy_a[1] && !s_q.pa && !s_q.sy_b[1] && !s_q.pb;
  endsequence
  sequence s_count_down;
    ch2_out.cnt_en && ch2_out.cnt_down;
  endsequence

  AST_QUAD_DOWN: assert property (s_a_rise_b_low |=> s_count_down)
    else $error("a rise with b low did not count down");
  AST_QUAD_IGN: assert property (s_q.quad && s_q.sy_a[1] == s_q.pa &&
    s_q.sy_b[1] == s_q.pb |=> !ch2_out.cnt_en)
    else $error("quad mode counted without a phase edge");
  AST_A_SET: assert property (evt_in.match_a[0] |=> s_q.fl_a[0])
    else $error("match a flag not set");
  AST_B_SET: assert property (evt_in.match_b[1] |=> s_q.fl_b[1])
    else $error("match b flag not set");
  AST_DMA_CLR: assert property (dma_start_a_in[0] && !evt_in.match_a[0]
    |=> !s_q.fl_a[0])
    else $error("dma start left match a flag set");
  AST_HOLD_ONE: assert property (s_q.fl_b[0] && quiet |=> s_q.fl_b[0] ##1
    (s_q.fl_b[0] || s_q.arm_b[0] || !$past(s_q.wreq)))
    else $error("flag lost without a zero write");
  AST_UDF_NORM: assert property (!s_q.quad && !s_q.fl_w[2] &&
    evt_in.udf2 && !evt_in.ovf[2] |=> !s_q.fl_w[2])
    else $error("underflow flagged outside quad mode");
  AST_UDF_WRAP_CONDITION_BIT: assert property (s_q.quad && s_q.wrap_condition_bit && !s_q.fl_w[2] &&
    evt_in.udf2 && !evt_in.ovf[2] |=> !s_q.fl_w[2])
    else $error("underflow flagged with overflow-only select");
  AST_PWM_HI: assert property (s_q.pwm[1] && evt_in.match_a[1] &&
    !evt_in.match_b[1] && !$rose(s_q.wreq) |=> chan_a_pin_out.o[1] &&
    chan_a_pin_out.oe[1])
    else $error("pwm pin not set on match a");
  AST_IRQ_AND: assert property (irq_out.w == (s_q.fl_w & s_q.en_w))
    else $error("wrap request differs from flag and enable");
  AST_RSVD: assert property (!av_waitrequest_out && $past(av_read_in) &&
    $past(av_address_in) == IDX_STA |-> av_readdata_out[7] &&
    av_readdata_out[3])
    else $error("reserved status bits did not read one");
  AST_BUS_WAIT: assert property ($fell(av_waitrequest_out) |=>
    av_waitrequest_out)
    else $error("waitrequest low for more than one cycle");
endmodule

// ===== testbench/quad_encoder_model.sv
// two-phase encoder model that drives the channel 2 phase pins
// assumes step and direction come from the bench on clk_in
`timescale 1ns/100ps
module quad_encoder_model (
  input  wire logic clk_in,
  input  wire logic step_in,
  input  wire logic down_in,
  output logic      phase_a_out,
  output logic      phase_b_out
);
  // ==========================================
  // gray position: only one pin moves per step
  logic [1:0] pos_q;  // place in the four-step cycle
  initial pos_q = 2'h0;
  // a,b walk 00 10 11 01 downwards, the reverse upwards
  always @(posedge clk_in) begin
    if (step_in) begin
      pos_q <= down_in ? pos_q + 2'h1 : pos_q - 2'h1;
    end
  end
  // phases never both change, so no count is lost
  assign phase_a_out = pos_q[1] ^ pos_q[0];
  assign phase_b_out = pos_q[1];
endmodule

// ===== testbench/tb.sv
// self-checking bench for the timer mode and status block
// assumes the avalon slave answers after one wait cycle
`timescale 1ns/100ps
module tb;
  import tms_pkg::*;
  // ==========================================
  // design connections
  logic        clk_in, rst_in, standby_in, ch2_norm_tick_in;
  logic        av_read_in, av_write_in, av_waitrequest_out;
  logic [2:0]  av_address_in, dma_start_a_in;
  logic [31:0] av_writedata_in, av_readdata_out;
  logic [3:0]  av_byteenable_in;
  logic        pin_a, pin_b, step, step_dn;  // encoder pins and control
  chan_evt_t   evt_in;
  io_t         cmp_io_in, chan_a_pin_out;
  irq_t        irq_out;
  ch2_ctl_t    ch2_out;
  int          num_errors, total_checks, n_up, n_dn;
  logic [7:0]  rd;  // last read byte
  timer_mode_status u_dut (
    .clk_in, .rst_in, .standby_in, .av_address_in, .av_read_in, .av_write_in,
    .av_writedata_in, .av_byteenable_in, .av_readdata_out, .av_waitrequest_out,
    .ext_clk_a_pin_in(pin_a), .ext_clk_b_pin_in(pin_b), .ch2_norm_tick_in,
    .evt_in, .dma_start_a_in, .cmp_io_in, .chan_a_pin_out, .irq_out, .ch2_out);
  quad_encoder_model u_enc (.clk_in, .step_in(step), .down_in(step_dn),
    .phase_a_out(pin_a), .phase_b_out(pin_b));
  // ==========================================
  // clock and count strobe tally
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // tally at the falling edge, where the one-cycle strobe is settled
  always @(negedge clk_in) begin
    if (ch2_out.cnt_en === 1'b1) begin
      if (ch2_out.cnt_down === 1'b1) n_dn++;
      else n_up++;
    end
  end
  // ==========================================
  // shared tasks
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  // one avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_in);
    av_address_in   <= a;
    av_writedata_in <= {24'h0, d};
    av_write_in     <= w;
    av_read_in      <= !w;
    // look mid-cycle, so the edge that follows is the one that sees it low
    for (n = 0; n < 40; n++) begin
      @(negedge clk_in);
      if (av_waitrequest_out === 1'b0) break;
    end
    @(posedge clk_in);
    rd = av_readdata_out[7:0];
    av_write_in <= 1'b0;
    av_read_in  <= 1'b0;
    if (n == 40) begin
      num_errors++;
      wrap_up();
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rc(input logic [2:0] a, input logic [7:0] e, input string nm);
    bus(1'b0, a, 8'h00);
    chk(nm, e, rd);
  endtask
  // one-cycle strobes: events, dma starts, tick, standby
  task automatic pulse(input chan_evt_t e, input logic [2:0] d, input logic t,
                       input logic s);
    @(posedge clk_in);
    evt_in           <= e;
    dma_start_a_in   <= d;
    ch2_norm_tick_in <= t;
    standby_in       <= s;
    @(posedge clk_in);
    evt_in           <= '0;
    dma_start_a_in   <= 3'h0;
    ch2_norm_tick_in <= 1'b0;
    standby_in       <= 1'b0;
  endtask
  // one encoder step, then room for the synchroniser
  task automatic enc(input logic dn);
    @(posedge clk_in);
    step    <= 1'b1;
    step_dn <= dn;
    @(posedge clk_in);
    step <= 1'b0;
    repeat (6) @(posedge clk_in);
  endtask
  // hang guard
  initial begin
    repeat (20000) @(posedge clk_in);
    num_errors++;
    wrap_up();
  end
  // ==========================================
  // main sequence
  initial begin
    {rst_in, standby_in, ch2_norm_tick_in, av_read_in, av_write_in} = 5'h10;
    {av_address_in, dma_start_a_in, av_writedata_in, step, step_dn} = '0;
    av_byteenable_in = 4'hf;
    evt_in = '0;
    cmp_io_in = 6'h3f;  // compare path drives all pins high
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    // reset values, reserved bits, unmapped words
    rc(3'h0, 8'h98, "mode reset");
    for (int r = 1; r < 4; r++) rc(3'(r), 8'h88, "status reset");
    wr(3'h0, 8'hff);
    rc(3'h0, 8'hff, "mode all ones");
    wr(3'h0, 8'h00);
    rc(3'h0, 8'h98, "mode cleared");
    wr(3'h5, 8'hff);
    rc(3'h5, 8'h00, "unmapped");
    $display("test registers done");
    // flags, enables, requests and clearing in each status word
    for (int r = 1; r < 4; r++) begin
      wr(3'(r), 8'h70);
      rc(3'(r), 8'hf8, "enables");
      pulse(r == 1 ? 10'h380 : r == 2 ? 10'h070 : 10'h00e, 3'h0, 1'b0, 1'b0);
      rc(3'(r), 8'hff, "flags set");
      @(negedge clk_in);
      chk("irq on", 8'h07, {5'h0, r == 1 ? irq_out.a : r == 2 ? irq_out.b : irq_out.w});
      wr(3'(r), 8'h77);
      wr(3'(r), 8'h70);
      rc(3'(r), 8'hff, "flags kept");
      wr(3'(r), 8'h07);
      @(negedge clk_in);
      chk("irq masked", 8'h00, {5'h0, r == 1 ? irq_out.a : r == 2 ? irq_out.b : irq_out.w});
      rc(3'(r), 8'h8f, "flags armed");
      wr(3'(r), 8'h00);
      rc(3'(r), 8'h88, "flags cleared");
    end
    $display("test flags done");
    // dma start clears match a only; standby restores everything
    pulse(10'h3f0, 3'h5, 1'b0, 1'b0);
    pulse(10'h000, 3'h5, 1'b0, 1'b0);
    rc(3'h1, 8'h8a, "dma clear a");
    rc(3'h2, 8'h8f, "dma keeps b");
    wr(3'h0, 8'h67);
    pulse(10'h000, 3'h0, 1'b0, 1'b1);
    rc(3'h0, 8'h98, "mode standby");
    for (int r = 1; r < 4; r++) rc(3'(r), 8'h88, "status standby");
    $display("test dma and standby done");
    // wrap condition for channel 2
    wr(3'h0, 8'h40);
    pulse(10'h001, 3'h0, 1'b0, 1'b0);
    rc(3'h3, 8'h8c, "underflow both");
    pulse(10'h000, 3'h0, 1'b0, 1'b1);
    wr(3'h0, 8'h60);
    pulse(10'h001, 3'h0, 1'b0, 1'b0);
    rc(3'h3, 8'h88, "underflow off");
    pulse(10'h008, 3'h0, 1'b0, 1'b0);
    rc(3'h3, 8'h8c, "overflow only");
    pulse(10'h000, 3'h0, 1'b0, 1'b1);
    pulse(10'h001, 3'h0, 1'b0, 1'b0);
    rc(3'h3, 8'h88, "underflow normal");
    $display("test wrap done");
    // pwm on channel 1 only; the others follow the compare path
    @(negedge clk_in);
    chk("pin normal", 8'h3f, {2'h0, chan_a_pin_out});
    wr(3'h0, 8'h02);
    pulse(10'h020, 3'h0, 1'b0, 1'b0);
    @(negedge clk_in);
    chk("pwm low", 8'h2f, {2'h0, chan_a_pin_out});
    pulse(10'h100, 3'h0, 1'b0, 1'b0);
    @(negedge clk_in);
    chk("pwm high", 8'h3f, {2'h0, chan_a_pin_out});
    $display("test pwm done");
    // quadrature counting; the normal tick is ignored meanwhile
    pulse(10'h000, 3'h0, 1'b0, 1'b1);
    wr(3'h0, 8'h40);
    @(negedge clk_in);
    chk("quad", 8'h01, {7'h0, ch2_out.quad});
    n_up = 0;
    n_dn = 0;
    repeat (4) enc(1'b1);
    pulse(10'h200, 3'h0, 1'b1, 1'b0);
    repeat (6) @(posedge clk_in);
    chk("down count", 8'h04, 8'(n_dn));
    rc(3'h1, 8'h8c, "quad flags");
    repeat (4) enc(1'b0);
    chk("up count", 8'h04, 8'(n_up));
    wr(3'h0, 8'h00);
    pulse(10'h000, 3'h0, 1'b1, 1'b0);
    repeat (6) @(posedge clk_in);
    chk("normal tick", 8'h05, 8'(n_up));
    $display("test quadrature done");
    wrap_up();
  end
endmodule
